// *** logic/sps_sequencer.sv ***
// stepper phase sequencer with apb access to mode bits and fault status
// Notes on behaviour
// - edge select high: step on rising edges
// - edge select low: step on both edges
// - excitation low full-step, high half-step
// - direction low forward, high reverse
// - reset low holds sequencer in reset
// - reset release starts at A and BB
// - enable low forces all phases off
// - enable high resumes at the position reached, counting steps seen while off
// - fault pin low on overcurrent or overheat
// - fault latches outputs off until reset
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module sps_sequencer
    import sps_pkg::*;
(
    // clock and resets
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sequencer_reset_n,

    // controller pins
    input wire logic step_clock,
    input wire logic excitation_select,
    input wire logic step_edge_select,
    input wire logic rotation_direction,
    input wire logic output_enable,

    // detector inputs
    input wire logic overcurrent_detect,
    input wire logic overheat_detect,

    // register bus requests
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,

    // register bus answers
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,

    // phase drive
    output logic phase_out_a,
    output logic phase_out_first_inv,
    output logic phase_out_b,
    output logic phase_out_second_inv,

    // fault pin
    output logic fault_n
);
    // timing notes
    // step_clock is sampled on pclk and compared with its last sample, so the
    // controller must hold each level for at least one pclk period; a shorter
    // pulse is lost without warning
    // phase outputs and fault_n are registered; the phases follow a step edge or an
    // enable change by one pclk, and both follow a detect by two pclks
    // steps seen while the outputs are disabled still move the position, so
    // the motor resumes in step with the controller
    // detects latch; only presetn or sequencer_reset_n clears them, and a
    // detect in the same cycle as the clear keeps the latch set
    // the bus bits are ored with the pins: software can add a mode or force
    // the outputs off, but never undo a pin
    // a change of excitation mode keeps the position; a full step taken from a
    // single-phase position starts from the next position up, so it lands on a pair
    // pready is always high, so every transfer takes one setup and one access
    // cycle

    // half-step position map, {a, first_inv, b, second_inv}
    //   0: 1000  1: 1100  2: 0100  3: 0110
    //   4: 0010  5: 0011  6: 0001  7: 1001 (reset)
    // odd positions drive two phases; full-step only ever lands on them
    // register map
    //   ctrl 0x000: bit0 half-step, bit1 rising only, bit2 reverse, bit3 force off
    //   stat 0x004: bit0 fault, 4:1 phases, 6 overheat, 7 overcurrent, 10:8 position
    //   0x008 reads zero, other offsets answer with pslverr

    // pattern at half-step position p, bit order {a, first_inv, b, second_inv}
    function automatic logic [3:0] sps_pattern(input logic [2:0] p);
        case (p)
            3'h0: sps_pattern = 4'b1000;
            3'h1: sps_pattern = 4'b1100;
            3'h2: sps_pattern = 4'b0100;
            3'h3: sps_pattern = 4'b0110;
            3'h4: sps_pattern = 4'b0010;
            3'h5: sps_pattern = 4'b0011;
            3'h6: sps_pattern = 4'b0001;
            3'h7: sps_pattern = 4'b1001;
            default: sps_pattern = SPS_PAT_OFF;
        endcase
    endfunction

    // address decode, shared by the write strobe, read mux and error flag
    function automatic logic sps_hit(input logic [11:0] a, input logic [11:0] ofs);
        sps_hit = (a == ofs);
    endfunction

    // one step of the half-step position in the chosen sense
    function automatic logic [2:0] sps_next(
        input logic [2:0] b,
        input logic [2:0] s,
        input logic rev
    );
        if (rev) begin
            sps_next = 3'(b - s);
        end else begin
            sps_next = 3'(b + s);
        end
    endfunction

    // control register
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;

    // read data next value
    logic [31:0] prdata_d;

    // step clock history
    logic step_clock_q;
    logic step_clock_d;

    // half-step position
    logic [2:0] pos_q;
    logic [2:0] pos_d;
    logic [2:0] stride;
    logic [2:0] base;

    // detection latches, bit 1 overcurrent, bit 0 overheat
    logic [1:0] det_q;
    logic [1:0] det_d;

    // phase drive and fault pin
    logic [3:0] phase_q;
    logic [3:0] phase_d;
    logic fault_n_q;
    logic fault_n_d;

    wire logic seq_rst = ~sequencer_reset_n;
    wire logic acc_phase = psel & penable;
    wire logic setup_rd = psel & ~penable & ~pwrite;
    wire logic wr_en = acc_phase & pwrite;

    wire logic sel_ctrl = sps_hit(paddr, SPS_CTRL_OFS);
    wire logic sel_stat = sps_hit(paddr, SPS_STAT_OFS);
    wire logic sel_fclr = sps_hit(paddr, SPS_FCLR_OFS);
    wire logic addr_ok = sel_ctrl | sel_stat | sel_fclr;

    // software bits are ored with the pins so either party may steer the mode
    wire logic exc_half = excitation_select | ctrl_q[SPS_CTRL_EXC_BIT];
    wire logic rise_only = step_edge_select | ctrl_q[SPS_CTRL_EDGE_BIT];
    wire logic dir_rev = rotation_direction | ctrl_q[SPS_CTRL_DIR_BIT];
    wire logic en = output_enable & ~ctrl_q[SPS_CTRL_EN_BIT];

    // step_clock resets low, its idle level, so no false edge after reset
    wire logic rise = step_clock & ~step_clock_q;
    wire logic fall = ~step_clock & step_clock_q;
    wire logic step_ev = rise | (~rise_only & fall);

    // dir_rev high steps backwards through the map
    wire logic [2:0] pos_step = sps_next(base, stride, dir_rev);

    // a latched detect keeps the stage off until a reset
    wire logic fault_any = |det_q;
    wire logic drive_ok = en & ~fault_any & ~seq_rst;

    // detect inputs gathered so the latch loop below can index them
    wire logic [1:0] det_in = {overcurrent_detect, overheat_detect};

    wire logic [31:0] stat_word = {21'h0, pos_q, det_q, 1'b0, phase_q, ~fault_n_q};
    wire logic [31:0] rd_mux = sel_ctrl ? ctrl_q :
                               sel_stat ? stat_word :
                               SPS_RDATA_ZERO;

    // next-state logic

    // full-step moves two positions and stays on odd (two-phase) positions
    always_comb begin
        stride = 3'h2;
        base = pos_q;
        if (exc_half) begin
            stride = 3'h1;
        end else if (!pos_q[0]) begin
            base = 3'(pos_q + 3'h1);
        end
    end

    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_en && sel_ctrl) begin
            ctrl_d = pwdata;
        end
    end

    // read data is loaded in the setup cycle so it stands through the access
    always_comb begin
        prdata_d = prdata;
        if (setup_rd) begin
            prdata_d = rd_mux;
        end
    end

    assign step_clock_d = step_clock;

    always_comb begin
        pos_d = pos_q;
        if (seq_rst) begin
            pos_d = SPS_POS_RST;
        end else if (step_ev) begin
            pos_d = pos_step;
        end
    end

    // latches: only a reset clears them, and a detect in the same cycle wins
    for (genvar i = 0; i < 2; i++) begin : g_det
        assign det_d[i] = det_in[i] | (det_q[i] & ~seq_rst);
    end

    always_comb begin
        phase_d = SPS_PAT_OFF;
        if (drive_ok) begin
            phase_d = sps_pattern(pos_d);
        end
    end

    assign fault_n_d = ~fault_any;

    // zero wait states; pready never drops
    assign pready = 1'b1;
    // unmapped offsets answer with an error and read zero
    assign pslverr = acc_phase & ~addr_ok;

    // registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= SPS_CTRL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= SPS_RDATA_ZERO;
        end else begin
            prdata <= prdata_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_clock_q <= 1'b0;
        end else begin
            step_clock_q <= step_clock_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_q <= SPS_POS_RST;
        end else begin
            pos_q <= pos_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            det_q <= 2'h0;
        end else begin
            det_q <= det_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= SPS_PAT_OFF;
        end else begin
            phase_q <= phase_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_n_q <= 1'b1;
        end else begin
            fault_n_q <= fault_n_d;
        end
    end

    // pin outputs

    assign phase_out_a = phase_q[3];
    assign phase_out_first_inv = phase_q[2];
    assign phase_out_b = phase_q[1];
    assign phase_out_second_inv = phase_q[0];
    assign fault_n = fault_n_q;
endmodule
`default_nettype wire

// *** logic/sps_pkg.sv ***
// shared constants for the stepper phase sequencer
package sps_pkg;
    localparam int unsigned SPS_CLK_HZ = 20000000;
    // register byte offsets
    localparam logic [11:0] SPS_CTRL_OFS = 12'h000;
    localparam logic [11:0] SPS_STAT_OFS = 12'h004;
    localparam logic [11:0] SPS_FCLR_OFS = 12'h008;
    // control field positions
    localparam int unsigned SPS_CTRL_EXC_BIT = 0;
    localparam int unsigned SPS_CTRL_EDGE_BIT = 1;
    localparam int unsigned SPS_CTRL_DIR_BIT = 2;
    localparam int unsigned SPS_CTRL_EN_BIT = 3;
    localparam logic [31:0] SPS_CTRL_RST = 32'h0000_0000;
    // position of the initial excitation (A and second-inv on)
    localparam logic [2:0] SPS_POS_RST = 3'h7;
    // half-step positions: even = single phase, odd = two phases
    localparam logic [3:0] SPS_PAT_OFF = 4'h0;
    localparam logic [31:0] SPS_RDATA_ZERO = 32'h0000_0000;
endpackage

// *** dv/sps_seq_props.sv ***
// pin-level assertions for the phase sequencer
`timescale 1ns/1ns
`default_nettype none
module sps_seq_props (
    input wire logic pclk, presetn, sequencer_reset_n, step_clock, step_edge_select, output_enable,
    input wire logic overcurrent_detect, overheat_detect, fault_n,
    input wire logic phase_out_a, phase_out_first_inv, phase_out_b, phase_out_second_inv
);
    wire logic [3:0] p = {phase_out_a, phase_out_first_inv, phase_out_b, phase_out_second_inv};
    wire logic q = sequencer_reset_n && output_enable && fault_n && !overcurrent_detect && !overheat_detect;
    logic ok_q;
    // q held over two edges, never across a reset release
    always_ff @(posedge pclk or negedge presetn) ok_q <= !presetn ? 1'b0 : q;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_off_disabled: assert property (!output_enable |=> p == 4'h0) else $error("phases on");
    a_seq_reset: assert property (!sequencer_reset_n |=> p == 4'h0) else $error("phases on");
    a_fault_low: assert property (overcurrent_detect || overheat_detect |-> ##[1:2] !fault_n) else $error("no fault");
    a_fault_off: assert property (!fault_n ##1 !fault_n |-> p == 4'h0) else $error("phases on");
    a_valid_pat: assert property (p != 4'h0 |-> p inside {4'h8, 4'hc, 4'h4, 4'h6, 4'h2, 4'h3, 4'h1, 4'h9})
        else $error("bad pattern");
    a_hold_idle: assert property (ok_q && q && $stable(step_clock) |=> $stable(p)) else $error("moved");
    a_rise_only: assert property (ok_q && q && step_edge_select && $fell(step_clock) |=> $stable(p))
        else $error("moved");
    a_both_edges: assert property (ok_q && q && !step_edge_select && $changed(step_clock) |=> $changed(p))
        else $error("no step");
    c_step: cover property (q && $rose(step_clock));
    c_fault: cover property (!fault_n);
    c_resume: cover property (!output_enable ##1 output_enable);
endmodule
`default_nettype wire

// *** dv/sps_ctl_model.sv ***
// motion controller stand-in: one step clock level change per request
`timescale 1ns/1ns
`default_nettype none
module sps_ctl_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    output logic step_clock
);
    // toggling keeps every level at least one pclk long
    always_ff @(posedge pclk or negedge presetn) step_clock <= !presetn ? 1'b0 : step_clock ^ go;
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// self-checking bench for the phase sequencer
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import sps_pkg::*;
    logic pclk = 0, presetn = 0, srn = 0, go = 0, exc = 1, edg = 1, dir = 0, en = 1, oc = 0, oh = 0;
    logic psel = 0, penable = 0, pwrite = 0, sc, pready, er, fault_n, se;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] ph, pat [8] = '{4'h8, 4'hc, 4'h4, 4'h6, 4'h2, 4'h3, 4'h1, 4'h9};
    logic [2:0] pos = SPS_POS_RST, st;
    int bad_count = 0, n_compared = 0;
    initial forever #25 pclk = ~pclk;
    sps_ctl_model ctl_u (.pclk(pclk), .presetn(presetn), .go(go), .step_clock(sc));
    sps_sequencer dut_u (.pclk(pclk), .presetn(presetn), .sequencer_reset_n(srn), .step_clock(sc),
        .excitation_select(exc), .step_edge_select(edg), .rotation_direction(dir), .output_enable(en),
        .overcurrent_detect(oc), .overheat_detect(oh), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(er), .phase_out_a(ph[3]),
        .phase_out_first_inv(ph[2]), .phase_out_b(ph[1]), .phase_out_second_inv(ph[0]), .fault_n(fault_n));
    task automatic chk(input string s, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic edge1();
        go <= 1;
        tick(1);
        go <= 0;
        tick(3);
        st = exc ? 3'd1 : 3'd2;
        if (sc === 1'b1 || !edg) pos = dir ? pos - st : pos + st;
        chk("phases", ph, en ? pat[pos] : 4'h0);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        tick(1);
        penable <= 1;
        for (int i = 0; i < 9; i++) begin
            tick(1);
            if (pready === 1'b1) break;
            if (i == 8) begin
                bad_count++;
                close_out();
            end
        end
        rd = prdata;
        se = er;
        psel <= 0;
        penable <= 0;
        tick(1);
    endtask
    initial begin
        tick(6);
        presetn <= 1;
        srn <= 1;
        tick(2);
        chk("init", ph, 4'h9);
        repeat (16) edge1();
        dir <= 1;
        edg <= 0;
        tick(1);
        repeat (2) edge1();
        exc <= 0;
        tick(3);
        chk("mode", ph, pat[pos]);
        repeat (4) edge1();
        en <= 0;
        tick(1);
        repeat (3) edge1();
        en <= 1;
        tick(3);
        chk("resume", ph, pat[pos]);
        for (int k = 0; k < 2; k++) begin
            {oc, oh} <= k ? 2'b01 : 2'b10;
            tick(1);
            {oc, oh} <= 2'b00;
            tick(3);
            chk("fault", {fault_n, ph}, 5'h00);
            srn <= 0;
            tick(2);
            chk("held", ph, 4'h0);
            srn <= 1;
            tick(2);
            chk("clear", {fault_n, ph}, 5'h19);
            pos = SPS_POS_RST;
        end
        apb(0, SPS_STAT_OFS, 0);
        chk("stat", rd, 32'h0000_0712);
        apb(1, SPS_CTRL_OFS, 32'h1);
        apb(0, SPS_CTRL_OFS, 0);
        chk("ctrl", rd, 32'h1);
        apb(0, 12'h100, 0);
        chk("unmapped", {se, rd[30:0]}, 32'h8000_0000);
        close_out();
    end
endmodule
bind sps_sequencer sps_seq_props props_u (.pclk(pclk), .presetn(presetn), .sequencer_reset_n(sequencer_reset_n),
    .step_clock(step_clock), .step_edge_select(step_edge_select), .output_enable(output_enable),
    .overcurrent_detect(overcurrent_detect), .overheat_detect(overheat_detect), .fault_n(fault_n),
    .phase_out_a(phase_out_a), .phase_out_first_inv(phase_out_first_inv), .phase_out_b(phase_out_b),
    .phase_out_second_inv(phase_out_second_inv));
`default_nettype wire
